// >>> verilog/vfdst_top.sv
// vfdst_top: scan timing, display memory and pin sharing of the display
// controller, with an AHB-Lite register slave.
// assumes: a single AHB-Lite master; word transfers only; one clock.
//
// Summary of operation
// - digit blanked by cut width at both ends
// - segment pulses carry the same cut
// - first cycle after start drives zeros on digit and segment pins; port pins keep their latches
// - display cycle is 1024 or 2048 clocks
// - one key scan slot after last digit
// - two to sixteen scanned digits selectable
// - eight digit pulse width settings
// - pins assigned digits first, then segments
// - unassigned pins from pin 13 up act as ports; below it they drive zero
// - segment data held in display memory
// - display memory read without processor involvement
// - unused display memory works as plain RAM
// - key scan: outputs zero, port latches out
// - static display through port latches while stopped
// - key scan indication bit, read only
`timescale 1ns/1ns
module vfdst_top #(
    parameter int CYCLE_SHORT = vfdst_pkg::CYC_SHORT,
    parameter int CYCLE_LONG = vfdst_pkg::CYC_LONG
) (
    input wire logic clk_sys,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // shared display pins
    output logic [vfdst_pkg::NUM_PINS-1:0] pin_out,
    output logic key_scan_indication
);
    localparam logic [11:0] LEN_SHORT = 12'(CYCLE_SHORT);
    localparam logic [11:0] LEN_LONG = 12'(CYCLE_LONG);
    localparam logic [11:0] PORT_END = vfdst_pkg::ADDR_PORT_BASE +
        12'(4 * vfdst_pkg::NUM_PORTS);
    localparam logic [11:0] DMEM_END = vfdst_pkg::ADDR_DMEM_BASE +
        12'(4 * vfdst_pkg::DMEM_BYTES);

    // the counter is 11 bits and a cut step must be a whole clock
    if (CYCLE_SHORT < 16 || CYCLE_LONG > 2048 ||
        CYCLE_SHORT > CYCLE_LONG ||
        (CYCLE_SHORT % 16) != 0 || (CYCLE_LONG % 16) != 0) begin : g_bad
        $error("vfdst_top: display cycle lengths not supported");
    end

    // ---------------- registers ----------------
    vfdst_pkg::vfdst_cfg_t cfg_q;
    logic [7:0] port_q [vfdst_pkg::NUM_PORTS];
    logic [7:0] dmem [vfdst_pkg::DMEM_BYTES];

    // ---------------- bus data phase ----------------
    logic addr_take;
    logic dp_valid_q;
    logic dp_write_q;
    logic [11:0] dp_addr_q;
    logic rd_done_q;
    logic [31:0] hrdata_q;
    logic [7:0] rd_byte;
    logic wr_fire;
    logic [11:0] port_off;
    logic [11:0] dmem_off;
    logic in_port;
    logic in_dmem;
    logic [2:0] port_idx;
    logic [6:0] dmem_idx;

    // ---------------- scan timing ----------------
    vfdst_pkg::vfdst_state_t state_q;
    logic [10:0] cnt_q;
    logic [3:0] dig_q;
    logic [11:0] len_cyc;
    logic [11:0] cut_cyc;
    logic [11:0] cnt12;
    logic slot_end;
    logic active;
    logic [4:0] ndig;
    logic [5:0] nseg;
    logic last_digit;
    logic [39:0] seg_row;
    logic [39:0] port_vec;
    vfdst_pkg::vfdst_drive_t drive;

    // ---------------- AHB-Lite slave ----------------
    assign addr_take = hsel && htrans[1] && hready;
    assign port_off = dp_addr_q - vfdst_pkg::ADDR_PORT_BASE;
    assign dmem_off = dp_addr_q - vfdst_pkg::ADDR_DMEM_BASE;
    assign in_port = dp_addr_q >= vfdst_pkg::ADDR_PORT_BASE &&
        dp_addr_q < PORT_END;
    assign in_dmem = dp_addr_q >= vfdst_pkg::ADDR_DMEM_BASE &&
        dp_addr_q < DMEM_END;
    assign port_idx = port_off[4:2];
    assign dmem_idx = dmem_off[8:2];
    assign wr_fire = dp_valid_q && dp_write_q;

    // reads take one wait state so a write just before is seen
    assign hreadyout = !(dp_valid_q && !dp_write_q && !rd_done_q);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 12'h000;
        end else if (hready) begin
            dp_valid_q <= addr_take;
            dp_write_q <= hwrite;
            dp_addr_q <= {haddr[11:2], 2'b00};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_done_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end else if (dp_valid_q && !dp_write_q && !rd_done_q) begin
            rd_done_q <= 1'b1;
            hrdata_q <= {24'h00_0000, rd_byte};
        end else if (hready) begin
            rd_done_q <= 1'b0;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (dp_addr_q == vfdst_pkg::ADDR_CFG_FIRST) begin
            rd_byte[vfdst_pkg::CFG1_KSI_BIT] =
                (state_q == vfdst_pkg::ST_KEYSCAN);
            rd_byte[vfdst_pkg::CFG1_ENABLE_BIT] = cfg_q.enable;
            rd_byte[vfdst_pkg::CFG1_SEG_LSB +: 6] = cfg_q.seg_count;
        end else if (dp_addr_q == vfdst_pkg::ADDR_CFG_SECOND) begin
            rd_byte[vfdst_pkg::CFG2_LONG_BIT] = cfg_q.long_cycle;
            rd_byte[vfdst_pkg::CFG2_CUT_LSB +: 3] = cfg_q.cut;
            rd_byte[vfdst_pkg::CFG2_DIG_LSB +: 4] = cfg_q.dig_code;
        end else if (in_port) begin
            rd_byte = port_q[port_idx];
        end else if (in_dmem) begin
            rd_byte = dmem[dmem_idx];
        end
    end

    // configuration; the key scan bit is not writable
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg_q.enable <= vfdst_pkg::CFG_FIRST_RESET[
                vfdst_pkg::CFG1_ENABLE_BIT];
            cfg_q.seg_count <= vfdst_pkg::CFG_FIRST_RESET[
                vfdst_pkg::CFG1_SEG_LSB +: 6];
            cfg_q.long_cycle <= vfdst_pkg::CFG_SECOND_RESET[
                vfdst_pkg::CFG2_LONG_BIT];
            cfg_q.cut <= vfdst_pkg::CFG_SECOND_RESET[
                vfdst_pkg::CFG2_CUT_LSB +: 3];
            cfg_q.dig_code <= vfdst_pkg::CFG_SECOND_RESET[
                vfdst_pkg::CFG2_DIG_LSB +: 4];
        end else if (wr_fire) begin
            if (dp_addr_q == vfdst_pkg::ADDR_CFG_FIRST) begin
                cfg_q.enable <= hwdata[vfdst_pkg::CFG1_ENABLE_BIT];
                cfg_q.seg_count <= hwdata[vfdst_pkg::CFG1_SEG_LSB +: 6];
            end
            if (dp_addr_q == vfdst_pkg::ADDR_CFG_SECOND) begin
                cfg_q.long_cycle <= hwdata[vfdst_pkg::CFG2_LONG_BIT];
                cfg_q.cut <= hwdata[vfdst_pkg::CFG2_CUT_LSB +: 3];
                cfg_q.dig_code <= hwdata[vfdst_pkg::CFG2_DIG_LSB +: 4];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int p = 0; p < vfdst_pkg::NUM_PORTS; p++) begin
                port_q[p] <= vfdst_pkg::PORT_RESET;
            end
        end else if (wr_fire && in_port) begin
            port_q[port_idx] <= hwdata[7:0];
        end
    end

    // plain RAM: no reset, every byte open to software at all times
    always_ff @(posedge clk_sys) begin
        if (wr_fire && in_dmem) begin
            dmem[dmem_idx] <= hwdata[7:0];
        end
    end

    // ---------------- scan timing ----------------
    assign len_cyc = cfg_q.long_cycle ? LEN_LONG : LEN_SHORT;
    assign cut_cyc = 12'({9'h000, cfg_q.cut} *
        (len_cyc >> vfdst_pkg::CUT_STEP_SHIFT));
    assign cnt12 = {1'b0, cnt_q};
    // >= so a shorter cycle chosen mid-slot still ends the slot
    assign slot_end = cnt12 >= len_cyc - 12'h001;
    // blanking before and after the pulse, equal widths
    assign active = cnt12 >= cut_cyc && cnt12 < len_cyc - cut_cyc;

    // digit code 0 is not a legal count; two digits are used
    assign ndig = (cfg_q.dig_code == 4'h0) ? 5'(vfdst_pkg::NUM_DIG_MIN) :
        {1'b0, cfg_q.dig_code} + 5'h01;
    assign nseg = (cfg_q.seg_count > 6'(vfdst_pkg::NUM_SEG_MAX)) ?
        6'(vfdst_pkg::NUM_SEG_MAX) : cfg_q.seg_count;
    assign last_digit = {1'b0, dig_q} >= ndig - 5'h01;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= vfdst_pkg::ST_STOP;
            dig_q <= 4'h0;
        end else if (!cfg_q.enable) begin
            state_q <= vfdst_pkg::ST_STOP;
            dig_q <= 4'h0;
        end else begin
            case (state_q)
                vfdst_pkg::ST_STOP: begin
                    state_q <= vfdst_pkg::ST_FIRST;
                    dig_q <= 4'h0;
                end
                vfdst_pkg::ST_FIRST: begin
                    if (slot_end) begin
                        state_q <= vfdst_pkg::ST_DIGIT;
                        dig_q <= 4'h0;
                    end
                end
                vfdst_pkg::ST_DIGIT: begin
                    if (slot_end && last_digit) begin
                        state_q <= vfdst_pkg::ST_KEYSCAN;
                    end else if (slot_end) begin
                        dig_q <= dig_q + 4'h1;
                    end
                end
                vfdst_pkg::ST_KEYSCAN: begin
                    if (slot_end) begin
                        state_q <= vfdst_pkg::ST_DIGIT;
                        dig_q <= 4'h0;
                    end
                end
                default: begin
                    state_q <= vfdst_pkg::ST_STOP;
                    dig_q <= 4'h0;
                end
            endcase
        end
    end

    // one slot counter serves digit, first and key scan slots alike
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= 11'h000;
        end else if (!cfg_q.enable || state_q == vfdst_pkg::ST_STOP ||
                     slot_end) begin
            cnt_q <= 11'h000;
        end else begin
            cnt_q <= cnt_q + 11'h001;
        end
    end

    assign key_scan_indication =
        (state_q == vfdst_pkg::ST_KEYSCAN);

    // display memory fetch: a dedicated read port, so the processor
    // never waits on the scan and the scan never stalls
    always_comb begin
        seg_row = 40'h00_0000_0000;
        for (int c = 0; c < vfdst_pkg::DMEM_COLS; c++) begin
            seg_row[c*8 +: 8] =
                dmem[c * vfdst_pkg::DMEM_ROWS + int'(dig_q)];
        end
    end

    always_comb begin
        for (int p = 0; p < vfdst_pkg::NUM_PORTS; p++) begin
            port_vec[p*8 +: 8] = port_q[p];
        end
    end

    always_comb begin
        drive.running = (state_q != vfdst_pkg::ST_STOP) &&
            cfg_q.enable;
        drive.keyscan = (state_q == vfdst_pkg::ST_KEYSCAN);
        drive.ndig = ndig;
        drive.nseg = nseg;
        drive.digit_wave = 16'h0000;
        // first cycle and key scan leave both waves at zero
        if (state_q == vfdst_pkg::ST_DIGIT && active) begin
            drive.digit_wave[dig_q] = 1'b1;
        end
        drive.seg_wave = (state_q == vfdst_pkg::ST_DIGIT && active) ?
            seg_row : 40'h00_0000_0000;
    end

    // ---------------- shared pins ----------------
    for (genvar i = 0; i < vfdst_pkg::NUM_PINS; i++) begin : g_pin
        logic latch_bit;
        if (i >= vfdst_pkg::PORT_FIRST_PIN) begin : g_port
            assign latch_bit =
                port_vec[i - vfdst_pkg::PORT_FIRST_PIN];
        end else begin : g_noport
            assign latch_bit = 1'b0;
        end
        vfdst_pin #(
            .IDX(i)
        ) u_pin (
            .clk_sys(clk_sys),
            .reset(reset),
            .drive(drive),
            .latch_bit(latch_bit),
            .pin_out(pin_out[i])
        );
    end

endmodule : vfdst_top

// >>> verilog/vfdst_pkg.sv
// vfdst_pkg: constants, types and register map of the display scan block.
// assumes: one 20 MHz system clock; registers reached over AHB-Lite.
package vfdst_pkg;

    // display cycle lengths in system clock periods
    localparam int CYC_SHORT = 1024;
    localparam int CYC_LONG = 2048;
    // cut width steps: one step is one sixteenth of a display cycle
    localparam int CUT_STEP_SHIFT = 4;

    // pin and memory geometry
    localparam int NUM_PINS = 53;
    localparam int PORT_FIRST_PIN = 13;
    localparam int NUM_DIG_MIN = 2;
    localparam int NUM_DIG_MAX = 16;
    localparam int NUM_SEG_MAX = 40;
    localparam int NUM_PORTS = 5;
    localparam int DMEM_COLS = 5;
    localparam int DMEM_ROWS = 16;
    localparam int DMEM_BYTES = 80;

    // display memory as the processor sees it
    localparam logic [15:0] DMEM_CPU_FIRST = 16'hfa30;
    localparam logic [15:0] DMEM_CPU_LAST = 16'hfa7f;

    // bus word addresses
    localparam logic [11:0] ADDR_CFG_FIRST = 12'h000;
    localparam logic [11:0] ADDR_CFG_SECOND = 12'h004;
    localparam logic [11:0] ADDR_PORT_BASE = 12'h010;
    localparam logic [11:0] ADDR_DMEM_BASE = 12'h100;

    // display_config_first fields
    localparam int CFG1_SEG_LSB = 0;
    localparam int CFG1_ENABLE_BIT = 6;
    localparam int CFG1_KSI_BIT = 7;
    // display_config_second fields
    localparam int CFG2_LONG_BIT = 0;
    localparam int CFG2_CUT_LSB = 1;
    localparam int CFG2_DIG_LSB = 4;

    localparam logic [7:0] CFG_FIRST_RESET = 8'h00;
    localparam logic [7:0] CFG_SECOND_RESET = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_STOP = 2'b00,
        ST_FIRST = 2'b01,
        ST_DIGIT = 2'b11,
        ST_KEYSCAN = 2'b10
    } vfdst_state_t;

    typedef struct packed {
        logic enable;
        logic [5:0] seg_count;
        logic long_cycle;
        logic [2:0] cut;
        logic [3:0] dig_code;
    } vfdst_cfg_t;

    // per-slot drive shared by every pin
    typedef struct packed {
        logic running;
        logic keyscan;
        logic [4:0] ndig;
        logic [5:0] nseg;
        logic [15:0] digit_wave;
        logic [39:0] seg_wave;
    } vfdst_drive_t;

endpackage : vfdst_pkg

// >>> verilog/vfdst_pin.sv
// vfdst_pin: function select and output flip-flop of one shared pin.
// assumes: drive bundle comes from the scan timing in the same clock.
`timescale 1ns/1ns
module vfdst_pin #(
    parameter int IDX = 0
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire vfdst_pkg::vfdst_drive_t drive,
    input wire logic latch_bit,
    output logic pin_out
);
    localparam logic [6:0] IDX7 = 7'(IDX);
    localparam logic [6:0] PFIRST7 = 7'(vfdst_pkg::PORT_FIRST_PIN);
    localparam logic [6:0] SEGMAX7 = 7'(vfdst_pkg::NUM_SEG_MAX);

    if (IDX < 0 || IDX >= vfdst_pkg::NUM_PINS) begin : g_bad_idx
        $error("vfdst_pin: pin index out of range");
    end

    logic [6:0] ndig7;
    logic [6:0] disp_end;
    logic [6:0] seg_idx;
    logic pin_d;
    logic pin_q;

    assign ndig7 = {2'b00, drive.ndig};
    assign disp_end = ndig7 + {1'b0, drive.nseg};
    assign seg_idx = IDX7 - ndig7;

    always_comb begin
        pin_d = latch_bit;
        if (!drive.running) begin
            pin_d = latch_bit;
        end else if (drive.keyscan && IDX7 >= PFIRST7) begin
            pin_d = latch_bit;
        end else if (IDX7 < ndig7) begin
            // digit pins come first
            pin_d = (IDX < vfdst_pkg::NUM_DIG_MAX) ?
                drive.digit_wave[IDX[3:0]] : 1'b0;
        end else if (IDX7 < disp_end) begin
            pin_d = (seg_idx < SEGMAX7) ?
                drive.seg_wave[seg_idx[5:0]] : 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign pin_out = pin_q;

endmodule : vfdst_pin

// >>> tb/vfdst_properties.sv
// vfdst_properties: port-level checks on the display scan block.
// assumes: one AHB-Lite master, hready fed back from hreadyout.
`timescale 1ns/1ns
module vfdst_properties #(
    parameter int CYCLE_SHORT = 1024,
    parameter int CYCLE_LONG = 2048
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [vfdst_pkg::NUM_PINS-1:0] pin_out,
    input wire logic key_scan_indication
);
    logic rd_taken;
    logic wr_taken;
    logic [11:0] ks_run_q;
    logic [11:0] grid_run_q;
    assign rd_taken = hsel && htrans[1] && hready && !hwrite;
    assign wr_taken = hsel && htrans[1] && hready && hwrite;
    // run lengths, since a stuck slot counter never shows in one cycle
    always_ff @(posedge clk_sys) begin
        if (reset || !key_scan_indication) ks_run_q <= 12'h000;
        else ks_run_q <= ks_run_q + 12'h001;
    end
    always_ff @(posedge clk_sys) begin
        if (reset || !pin_out[0]) grid_run_q <= 12'h000;
        else grid_run_q <= grid_run_q + 12'h001;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    chk_ks_pins_low: assert property (
        key_scan_indication && $past(key_scan_indication)
        |-> pin_out[12:0] == 13'h0000)
        else $error("display pins active in key scan");
    chk_one_grid: assert property (
        !(pin_out[0] && pin_out[1]))
        else $error("two digit pins lit together");
    chk_grid_run: assert property (
        grid_run_q <= CYCLE_LONG)
        else $error("digit pulse longer than a display cycle");
    chk_ks_run: assert property (
        ks_run_q <= CYCLE_LONG)
        else $error("key scan slot too long");
    chk_ks_min: assert property (
        $rose(key_scan_indication) |=> key_scan_indication [*8])
        else $error("key scan slot cut short");
    chk_grid_rise: assert property (
        $rose(pin_out[0]) |-> !key_scan_indication)
        else $error("digit lit during key scan");
    chk_read_wait: assert property (
        rd_taken |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (
        wr_taken |=> hreadyout)
        else $error("write stalled");
    chk_rdata_byte: assert property (
        $rose(hreadyout) |-> hrdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_resp_okay: assert property (
        hresp == 1'b0)
        else $error("bus response not okay");
    cover property ($rose(key_scan_indication));
    cover property (rd_taken);
    cover property ($rose(pin_out[0]));
endmodule : vfdst_properties

bind vfdst_top vfdst_properties #(
    .CYCLE_SHORT(CYCLE_SHORT), .CYCLE_LONG(CYCLE_LONG)
) u_props (
    .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pin_out(pin_out),
    .key_scan_indication(key_scan_indication)
);

// >>> tb/vfdst_panel.sv
// vfdst_panel: one grid of the display panel; times each lit pulse.
// assumes: grid wired to the first digit pin, same clock as the block.
`timescale 1ns/1ns
module vfdst_panel (
    input wire logic clk_sys,
    input wire logic grid,
    output logic lit_done,
    output logic [11:0] lit_len
);
    logic [11:0] run_q = 12'h000;
    // a pulse is reported only once the grid drops again
    always_ff @(posedge clk_sys) begin
        lit_done <= 1'b0;
        if (grid) begin
            run_q <= run_q + 12'h001;
        end else begin
            lit_done <= (run_q != 12'h000);
            lit_len <= run_q;
            run_q <= 12'h000;
        end
    end
endmodule : vfdst_panel

// >>> tb/vfdst_top_bench.sv
// vfdst_top_bench: self-checking bench for the display scan block.
// assumes: bench is the only AHB-Lite master; shortened display cycles.
`timescale 1ns/1ns
module vfdst_top_bench;
    localparam int LS = 64;
    localparam int LL = 128;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h00000000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [vfdst_pkg::NUM_PINS-1:0] pin_out;
    logic key_scan_indication;
    logic lit_done;
    logic [11:0] lit_len;
    logic rd_pend = 1'b0;
    logic [31:0] exp_rd[$];
    logic [31:0] exp_len[$];
    int failures = 0;
    int n_tests = 0;
    int seed = 25;

    always #25 clk_sys = ~clk_sys;

    vfdst_top #(.CYCLE_SHORT(LS), .CYCLE_LONG(LL)) DUT (
        .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .pin_out(pin_out),
        .key_scan_indication(key_scan_indication));
    vfdst_panel u_panel (.clk_sys(clk_sys), .grid(pin_out[0]),
        .lit_done(lit_done), .lit_len(lit_len));

    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task automatic compare(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (e !== g) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : compare

    // hready is sampled as the bus master would, before this edge lands
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [7:0] d);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h00000, a};
        @(posedge clk_sys);
        while (!hreadyout) @(posedge clk_sys);
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        @(posedge clk_sys);
        while (!hreadyout) @(posedge clk_sys);
    endtask : xfer

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        xfer(1'b0, a, 8'h00);
    endtask : rd

    always @(posedge clk_sys) begin
        if (rd_pend && hreadyout) begin
            rd_pend = 1'b0;
            compare("hrdata", exp_rd.pop_front(), hrdata);
        end
        if (htrans[1] && hreadyout && !hwrite) rd_pend = 1'b1;
        if (lit_done) begin
            compare("pulse", exp_len.pop_front(), 32'(lit_len));
        end
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        summarize();
    end

    initial begin
        logic [7:0] pv0;
        logic [7:0] pv4;
        logic [3:0] dc;
        logic lg;
        logic [1:0] sg;
        int n;
        int len;
        int lo;
        int cnt;
        pv0 = 8'($random(seed));
        pv4 = 8'($random(seed));
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(vfdst_pkg::ADDR_CFG_FIRST, 32'h0);
        rd(vfdst_pkg::ADDR_CFG_SECOND, 32'h0);
        xfer(1'b1, 12'h0f0, 8'hff);
        rd(12'h0f0, 32'h0);
        xfer(1'b1, vfdst_pkg::ADDR_CFG_FIRST, 8'h80);
        rd(vfdst_pkg::ADDR_CFG_FIRST, 32'h0);
        xfer(1'b1, vfdst_pkg::ADDR_DMEM_BASE + 12'h13c, 8'h5a);
        rd(vfdst_pkg::ADDR_DMEM_BASE + 12'h13c, 32'h5a);
        xfer(1'b1, vfdst_pkg::ADDR_PORT_BASE, pv0);
        xfer(1'b1, vfdst_pkg::ADDR_PORT_BASE + 12'h010, pv4);
        repeat (3) @(posedge clk_sys);
        compare("stopped", {11'h0, pv0, 13'h0}, 32'(pin_out[20:0]));
        // digit 0 lights segments 0 and 8; every other digit is dark in columns 0 and 1
        for (int i = 0; i < 32; i++)
            xfer(1'b1, vfdst_pkg::ADDR_DMEM_BASE + 12'(4 * i),
                (i % 16 == 0) ? 8'h01 : 8'h00);
        for (int c = 0; c < 8; c++) begin
            dc = 4'($random(seed));
            lg = 1'($random(seed));
            n = (dc == 4'h0) ? 2 : int'(dc) + 1;
            len = lg ? LL : LS;
            lo = len + c * (len / 16);
            exp_len.push_back(32'(len - 2 * c * (len / 16)));
            xfer(1'b1, vfdst_pkg::ADDR_CFG_SECOND, {dc, 3'(c), lg});
            xfer(1'b1, vfdst_pkg::ADDR_CFG_FIRST, 8'h4e);
            cnt = 0;
            while (!pin_out[0]) begin
                @(posedge clk_sys);
                cnt++;
            end
            compare("start", 32'h1, 32'(cnt >= lo && cnt <= lo + 3));
            while (!key_scan_indication) begin
                @(posedge clk_sys);
                sg = {pin_out[n + 8], pin_out[n]};
                if (|pin_out[1:0])
                    compare("seg", 32'({2{pin_out[0]}}), 32'(sg));
            end
            compare("port", 32'(pv4), 32'(pin_out[52:45]));
            repeat (20) @(posedge clk_sys);
            // pins 13 to 15 carry display waves in digit slots; 16 to 20 only with enough digits
            compare("keyscan", 32'(pv0), 32'(pin_out[20:13]));
            rd(vfdst_pkg::ADDR_CFG_FIRST, 32'hce);
            rd(vfdst_pkg::ADDR_CFG_SECOND, {24'h0, dc, 3'(c), lg});
            xfer(1'b1, vfdst_pkg::ADDR_CFG_FIRST, 8'h00);
        end
        repeat (4) @(posedge clk_sys);
        summarize();
    end
endmodule : vfdst_top_bench
